/* verilog/quasi_ports.sv */
// ports 1, 2 and 3 with alternate functions, boot select, rtc load
//
// Overview of operation
// (R1) Port 2 and 3 reset high, weak pull-up
// (R2) Weakly held pin reads external level
// (R3) Written zero holds strong pull-down until one
// (R4) Zero-to-one write pulses strong driver briefly
// (R5) Port 2 drives address high byte externally
// (R6) Port 1 bits 0-3: timer2, serial 1
// (R7) Port 1 bit 4: rising-edge interrupt
// (R8) Port 1 bits 5,6: falling-edge interrupts
// (R9) Port 3: serial0, irqs, timers, strobes
// (R10) Select low forces external code fetch
// (R11) Rtc crystal load chosen by control bit
// (R12) Port 1 quasi-bidirectional, resets to ones
// (R13) Alternate output needs latch one
`timescale 1ns/1ps
`default_nettype none
module quasi_ports
  import port_pkg::*;
(
  // clock and reset
  input  wire logic        clock,
  input  wire logic        reset_n,
  // cpu latch writes
  input  wire logic        p1_wr,
  input  wire logic        p2_wr,
  input  wire logic        p3_wr,
  input  wire logic [7:0]  wr_data,
  // external bus use of port 2 and port 3 strobes
  input  wire logic        ext_bus_active,
  input  wire logic [7:0]  ext_addr_high,
  input  wire logic        ext_wr_strobe_n,
  input  wire logic        ext_rd_strobe_n,
  // peripheral outputs borrowing pins
  input  wire logic        timer2_ext_out,
  input  wire logic        serial1_tx,
  input  wire logic        serial0_tx,
  // pads
  input  wire logic [7:0]  p1_pad_in,
  input  wire logic [7:0]  p2_pad_in,
  input  wire logic [7:0]  p3_pad_in,
  output logic [7:0]       p1_pulldown,
  output logic [7:0]       p1_boost,
  output logic [7:0]       p1_weak_up,
  output logic [7:0]       p2_pulldown,
  output logic [7:0]       p2_boost,
  output logic [7:0]       p2_weak_up,
  output logic [7:0]       p3_pulldown,
  output logic [7:0]       p3_boost,
  output logic [7:0]       p3_weak_up,
  // port reads
  output logic [7:0]       p1_latch,
  output logic [7:0]       p2_latch,
  output logic [7:0]       p3_latch,
  output logic [7:0]       p1_pins,
  output logic [7:0]       p2_pins,
  output logic [7:0]       p3_pins,
  // alternate inputs to peripherals
  output logic             timer2_ext_io,
  output logic             timer2_capture_trigger,
  output logic             serial1_rx,
  output logic             serial0_rx,
  output logic             ext_irq_zero,
  output logic             ext_irq_one,
  output logic             timer0_input,
  output logic             timer1_input,
  output logic             ext_irq_rising_a,
  output logic             ext_irq_falling_a,
  output logic             ext_irq_falling_b,
  // boot select and rtc load
  input  wire logic        external_program_select,
  input  wire logic        rtc_load_select,
  output logic             fetch_external,
  output logic             rtc_load_high
);
  // ==========================================================
  // wanted levels per port
  logic [7:0] p1_level;
  logic [7:0] p2_level;
  logic [7:0] p3_level;
  logic [7:0] p1_sync;
  logic [7:0] p2_sync;
  logic [7:0] p3_sync;
  logic [7:0] p1_q;
  logic [7:0] p2_q;
  logic [7:0] p3_q;

  // alternate outputs only pull low; a latch zero still wins
  assign p1_level = {4'hf, serial1_tx, 2'b11, timer2_ext_out};   // [R6] [R13]
  assign p2_level = ext_addr_high;                                // [R5]
  assign p3_level = {ext_rd_strobe_n, ext_wr_strobe_n,
                     4'hf, serial0_tx, 1'b1};                     // [R9] [R13]

  // ==========================================================
  // pin slices, one per bit and port
  genvar i;
  generate
    for (i = 0; i < PORT_W; i++) begin : g_pin
      quasi_pin u_p1 (
        .clock        (clock),
        .reset_n      (reset_n),
        .wr_en        (p1_wr),
        .wr_bit       (wr_data[i]),
        .drive_level  (p1_level[i]),
        .force_drive  (1'b0),
        .pad_in       (p1_pad_in[i]),
        .pad_pulldown (p1_pulldown[i]),
        .pad_boost    (p1_boost[i]),
        .pad_weak_up  (p1_weak_up[i]),
        .latch_q      (p1_q[i]),
        .pin_sync     (p1_sync[i])
      );
      // address drive replaces the latch during external cycles
      quasi_pin u_p2 (
        .clock        (clock),
        .reset_n      (reset_n),
        .wr_en        (p2_wr),
        .wr_bit       (wr_data[i]),
        .drive_level  (ext_bus_active ? p2_level[i] : 1'b1),
        .force_drive  (ext_bus_active),                           // [R5]
        .pad_in       (p2_pad_in[i]),
        .pad_pulldown (p2_pulldown[i]),
        .pad_boost    (p2_boost[i]),
        .pad_weak_up  (p2_weak_up[i]),
        .latch_q      (p2_q[i]),
        .pin_sync     (p2_sync[i])
      );
      quasi_pin u_p3 (
        .clock        (clock),
        .reset_n      (reset_n),
        .wr_en        (p3_wr),
        .wr_bit       (wr_data[i]),
        .drive_level  (p3_level[i]),
        .force_drive  (1'b0),
        .pad_in       (p3_pad_in[i]),
        .pad_pulldown (p3_pulldown[i]),
        .pad_boost    (p3_boost[i]),
        .pad_weak_up  (p3_weak_up[i]),
        .latch_q      (p3_q[i]),
        .pin_sync     (p3_sync[i])
      );
    end
  endgenerate

  assign p1_latch = p1_q;
  assign p2_latch = p2_q;
  assign p3_latch = p3_q;
  assign p1_pins  = p1_sync;
  assign p2_pins  = p2_sync;
  assign p3_pins  = p3_sync;

  // ==========================================================
  // alternate inputs and edge detection
  logic       rise_prev_reg;
  logic       fa_prev_reg;
  logic       fb_prev_reg;
  logic       rise_reg;
  logic       fa_reg;
  logic       fb_reg;
  logic [7:0] alt_reg;
  logic [2:0] sel_sync_reg;
  logic       fetch_ext_reg;
  logic       rtc_load_reg;
  wire        rise_ev = p1_sync[P1_IRQ_RISE] & ~rise_prev_reg;      // [R7]
  wire        fa_ev   = ~p1_sync[P1_IRQ_FALL_A] & fa_prev_reg;      // [R8]
  wire        fb_ev   = ~p1_sync[P1_IRQ_FALL_B] & fb_prev_reg;      // [R8]

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      rise_prev_reg <= 1'b1;
      fa_prev_reg   <= 1'b1;
      fb_prev_reg   <= 1'b1;
      rise_reg      <= 1'b0;
      fa_reg        <= 1'b0;
      fb_reg        <= 1'b0;
      alt_reg       <= PORT_RESET;
    end else begin
      rise_prev_reg <= p1_sync[P1_IRQ_RISE];
      fa_prev_reg   <= p1_sync[P1_IRQ_FALL_A];
      fb_prev_reg   <= p1_sync[P1_IRQ_FALL_B];
      rise_reg      <= rise_ev;
      fa_reg        <= fa_ev;
      fb_reg        <= fb_ev;
      alt_reg       <= {p3_sync[P3_T1], p3_sync[P3_T0],
                        p3_sync[P3_IRQ1], p3_sync[P3_IRQ0],
                        p3_sync[P3_S0_RX], p1_sync[P1_S1_RX],
                        p1_sync[P1_T2_TRIG], p1_sync[P1_T2_IO]}; // [R6] [R9]
    end
  end

  // ==========================================================
  // boot select through its own three-stage synchroniser, rtc load bit
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      sel_sync_reg  <= 3'b000;
      fetch_ext_reg <= 1'b1;
      rtc_load_reg  <= 1'b0;
    end else begin
      sel_sync_reg <= {sel_sync_reg[1:0], external_program_select};
      if (sel_sync_reg[1] == sel_sync_reg[2])
        fetch_ext_reg <= ~sel_sync_reg[2];                        // [R10]
      rtc_load_reg <= rtc_load_select;                            // [R11]
    end
  end

  assign timer2_ext_io          = alt_reg[0];
  assign timer2_capture_trigger = alt_reg[1];
  assign serial1_rx             = alt_reg[2];
  assign serial0_rx             = alt_reg[3];
  assign ext_irq_zero           = alt_reg[4];
  assign ext_irq_one            = alt_reg[5];
  assign timer0_input           = alt_reg[6];
  assign timer1_input           = alt_reg[7];
  assign ext_irq_rising_a       = rise_reg;
  assign ext_irq_falling_a      = fa_reg;
  assign ext_irq_falling_b      = fb_reg;
  assign fetch_external         = fetch_ext_reg;
  assign rtc_load_high          = rtc_load_reg;
endmodule : quasi_ports
`default_nettype wire

/* verilog/port_pkg.sv */
// constants shared by the quasi-bidirectional port block
package port_pkg;
  // ==========================================================
  // port geometry and reset values
  localparam int          PORT_W        = 8;
  localparam logic [7:0]  PORT_RESET    = 8'h0_0ff;
  // ==========================================================
  // timing of the strong transition driver
  localparam int          CLOCK_HZ      = 10_000_000;
  localparam int          BOOST_NS      = 200;
  localparam int          BOOST_CYCLES  =
    (BOOST_NS * (CLOCK_HZ / 1_000_000) / 1000) < 1 ? 1 :
    (BOOST_NS * (CLOCK_HZ / 1_000_000) / 1000);
  localparam logic [3:0]  BOOST_COUNT   = 4'(BOOST_CYCLES);
  // ==========================================================
  // port 1 alternate function bit positions
  localparam int          P1_T2_IO      = 0;
  localparam int          P1_T2_TRIG    = 1;
  localparam int          P1_S1_RX      = 2;
  localparam int          P1_S1_TX      = 3;
  localparam int          P1_IRQ_RISE   = 4;
  localparam int          P1_IRQ_FALL_A = 5;
  localparam int          P1_IRQ_FALL_B = 6;
  // ==========================================================
  // port 3 alternate function bit positions
  localparam int          P3_S0_RX      = 0;
  localparam int          P3_S0_TX      = 1;
  localparam int          P3_IRQ0       = 2;
  localparam int          P3_IRQ1       = 3;
  localparam int          P3_T0         = 4;
  localparam int          P3_T1         = 5;
  localparam int          P3_WR         = 6;
  localparam int          P3_RD         = 7;
endpackage : port_pkg

/* verilog/quasi_pin.sv */
// one quasi-bidirectional pin: latch, pull-down, boost, input sync
`timescale 1ns/1ps
`default_nettype none
module quasi_pin
  import port_pkg::*;
(
  // clock and reset
  input  wire logic       clock,
  input  wire logic       reset_n,
  // latch write from the cpu
  input  wire logic       wr_en,
  input  wire logic       wr_bit,
  // level wanted on the pin (latch and alternate / address)
  input  wire logic       drive_level,
  input  wire logic       force_drive,
  // pad
  input  wire logic       pad_in,
  output logic            pad_pulldown,
  output logic            pad_boost,
  output logic            pad_weak_up,
  // state
  output logic            latch_q,
  output logic            pin_sync
);
  logic       latch_reg;
  logic       level_reg;
  logic [3:0] boost_cnt_reg;
  logic       pd_reg;
  logic       weak_reg;
  logic       boost_reg;
  logic [2:0] sync_reg;
  logic       pin_reg;
  wire        level_next = force_drive ? drive_level : (latch_reg & drive_level);
  wire        rise       = level_next & ~level_reg;

  // ==========================================================
  // latch and driver control
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      latch_reg     <= 1'b1;                         // [R1] [R12]
      level_reg     <= 1'b1;
      pd_reg        <= 1'b0;
      weak_reg      <= 1'b1;
      boost_reg     <= 1'b0;
      boost_cnt_reg <= 4'h0;
    end else begin
      if (wr_en)
        latch_reg <= wr_bit;                         // [R3]
      level_reg <= level_next;
      pd_reg    <= ~level_next;                      // [R3] [R13]
      weak_reg  <= level_next;                       // [R2]
      if (rise) begin
        boost_reg     <= 1'b1;                       // [R4]
        boost_cnt_reg <= BOOST_COUNT;
      end else if (boost_cnt_reg > 4'h1) begin
        boost_cnt_reg <= boost_cnt_reg - 4'h1;
      end else begin
        boost_reg     <= 1'b0;                       // [R4]
        boost_cnt_reg <= 4'h0;
      end
      if (!level_next)
        boost_reg <= 1'b0;
    end
  end

  // ==========================================================
  // input path: a change counts once stages two and three agree
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      sync_reg <= 3'b111;
      pin_reg  <= 1'b1;
    end else begin
      sync_reg <= {sync_reg[1:0], pad_in};
      if (sync_reg[1] == sync_reg[2])
        pin_reg <= sync_reg[2];                      // [R2]
    end
  end

  assign pad_pulldown = pd_reg;
  assign pad_boost    = boost_reg;
  assign pad_weak_up  = weak_reg;                    // [R2]
  assign latch_q      = latch_reg;
  assign pin_sync     = pin_reg;
endmodule : quasi_pin
`default_nettype wire

/* test/quasi_ports_properties.sv */
// concurrent checks on the ports of the quasi-bidirectional block
`timescale 1ns/1ps
`default_nettype none
module quasi_ports_properties (
  // clock, reset and cpu side
  input wire logic       clock, reset_n, p1_wr, ext_bus_active,
  input wire logic       serial1_tx, ext_wr_strobe_n,
  input wire logic       external_program_select, rtc_load_select,
  input wire logic [7:0] wr_data, ext_addr_high,
  // pad controls and reads
  input wire logic [7:0] p1_pulldown, p1_boost, p1_weak_up,
  input wire logic [7:0] p2_pulldown, p3_pulldown,
  input wire logic [7:0] p1_latch, p2_latch, p3_latch, p1_pins, p3_pins,
  // peripheral side
  input wire logic       timer2_ext_io, serial0_rx, timer0_input,
  input wire logic       ext_irq_rising_a, ext_irq_falling_a,
  input wire logic       ext_irq_falling_b, fetch_external, rtc_load_high
);
  // ==========================================================
  // assertions
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);
  chk_reset_ones: assert property (
    $rose(reset_n) |-> (p1_latch & p2_latch & p3_latch) == 8'hff
      && p1_pulldown == 8'h00) else $error("ports not high after reset");
  chk_weak_inverse: assert property (
    p1_weak_up == ~p1_pulldown) else $error("weak pull-up not inverse");
  chk_latch_write: assert property (
    p1_wr |=> p1_latch == $past(wr_data)) else $error("latch missed write");
  chk_zero_pulls: assert property (
    1'b1 |=> p1_pulldown[7] == !$past(p1_latch[7]))
    else $error("pull-down does not follow latch");
  chk_boost_pulse: assert property (
    $fell(p1_pulldown[7]) |-> p1_boost[7] [*2] ##1 !p1_boost[7])
    else $error("strong driver pulse wrong");
  chk_no_fight: assert property (
    (p1_boost & p1_pulldown) == 8'h00) else $error("driver fights pull-down");
  chk_addr_high: assert property (
    ext_bus_active |=> p2_pulldown == ~$past(ext_addr_high))
    else $error("address byte not on port 2");
  chk_alt_drive: assert property (
    1'b1 |=> p1_pulldown[3] == !($past(p1_latch[3]) && $past(serial1_tx))
      && p3_pulldown[6] == !($past(p3_latch[6]) && $past(ext_wr_strobe_n)))
    else $error("alternate output level wrong");
  chk_alt_inputs: assert property (
    1'b1 |=> {timer2_ext_io, serial0_rx, timer0_input}
      == $past({p1_pins[0], p3_pins[0], p3_pins[4]}))
    else $error("alternate input not routed");
  chk_irq_rise: assert property (
    $rose(p1_pins[4]) |=> ext_irq_rising_a ##1 !ext_irq_rising_a)
    else $error("rising interrupt pulse wrong");
  chk_irq_fall_a: assert property (
    $fell(p1_pins[5]) |=> ext_irq_falling_a) else $error("falling irq a");
  chk_irq_fall_b: assert property (
    $fell(p1_pins[6]) |=> ext_irq_falling_b) else $error("falling irq b");
  chk_boot_sel: assert property (
    $fell(external_program_select) |-> ##[1:6] fetch_external)
    else $error("external fetch not selected");
  chk_rtc_load: assert property (
    1'b1 |=> rtc_load_high == $past(rtc_load_select))
    else $error("crystal load select lost");
  cover property ($fell(p1_pulldown[7]));
  cover property (ext_irq_rising_a);
  cover property (ext_bus_active);
endmodule // quasi_ports_properties
bind quasi_ports quasi_ports_properties props (.*);
`default_nettype wire

/* test/pad_model.sv */
// external circuit model resolving one port's eight pads
`timescale 1ns/1ps
`default_nettype none
module pad_model (
  // device pad controls
  input  wire logic [7:0] strong_low,
  input  wire logic [7:0] boost,
  input  wire logic [7:0] weak_up,
  // external drivers
  input  wire logic [7:0] ext_en,
  input  wire logic [7:0] ext_val,
  // resolved level
  output logic      [7:0] pad
);
  // strong pull-down beats everything; the weak pull-up loses to any driver
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (strong_low[i]) pad[i] = 1'b0;
      else if (boost[i]) pad[i] = 1'b1;
      else if (ext_en[i]) pad[i] = ext_val[i];
      else pad[i] = weak_up[i];
    end
  end
endmodule // pad_model
`default_nettype wire

/* test/quasi_ports_test.sv */
// self-checking bench for the quasi-bidirectional ports
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin checks_done++; if ((got) !== (exp)) begin \
  errors++; $display("[ERR] %0t got %h exp %h", $time, got, exp); end end
module quasi_ports_test;
  // ==========================================================
  // stimulus and observed nets
  logic clock = 0, reset_n = 0, p1_wr = 0, p2_wr = 0, p3_wr = 0;
  logic ext_bus_active = 0, ext_wr_strobe_n = 1, ext_rd_strobe_n = 1;
  logic timer2_ext_out = 1, serial1_tx = 1, serial0_tx = 1;
  logic external_program_select = 1, rtc_load_select = 0;
  logic [7:0] wr_data = 0, ext_addr_high = 0, p1_en = 0, p3_en = 0;
  logic [7:0] p1_pad_in, p2_pad_in, p3_pad_in, p1_pulldown, p1_boost;
  logic [7:0] p1_weak_up, p2_pulldown, p2_boost, p2_weak_up, p3_pulldown;
  logic [7:0] p3_boost, p3_weak_up, p1_latch, p2_latch, p3_latch;
  logic [7:0] p1_pins, p2_pins, p3_pins;
  logic timer2_ext_io, timer2_capture_trigger, serial1_rx, serial0_rx;
  logic ext_irq_zero, ext_irq_one, timer0_input, timer1_input;
  logic ext_irq_rising_a, ext_irq_falling_a, ext_irq_falling_b;
  logic fetch_external, rtc_load_high;
  int errors = 0, checks_done = 0, r, fa, fb;
  quasi_ports dut (.*);
  pad_model pm1 (.strong_low(p1_pulldown), .boost(p1_boost),
    .weak_up(p1_weak_up), .ext_en(p1_en), .ext_val(8'h00), .pad(p1_pad_in));
  pad_model pm2 (.strong_low(p2_pulldown), .boost(p2_boost),
    .weak_up(p2_weak_up), .ext_en(8'h00), .ext_val(8'h00), .pad(p2_pad_in));
  pad_model pm3 (.strong_low(p3_pulldown), .boost(p3_boost),
    .weak_up(p3_weak_up), .ext_en(p3_en), .ext_val(8'h00), .pad(p3_pad_in));
  always #50 clock = ~clock;
  // ==========================================================
  // helpers; inputs move only at the falling edge
  task automatic cyc(input int n); repeat (n) @(negedge clock); endtask
  task automatic wr(input int port, input logic [7:0] d);
    @(negedge clock);
    wr_data = d; p1_wr = port == 1; p2_wr = port == 2; p3_wr = port == 3;
    @(negedge clock);
    {p1_wr, p2_wr, p3_wr} = 3'b000;
  endtask
  task automatic drive_p1(input logic [7:0] en);
    p1_en = en; r = 0; fa = 0; fb = 0;
    repeat (10) begin
      @(negedge clock);
      r += ext_irq_rising_a === 1'b1;
      fa += ext_irq_falling_a === 1'b1;
      fb += ext_irq_falling_b === 1'b1;
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // ==========================================================
  // scenarios
  task automatic t_reset();
    `CHK(p1_latch, 8'hff)
    `CHK({p2_latch, p3_latch, p3_weak_up}, 24'hff_ffff)
    `CHK(p2_pulldown, 8'h00)
    $display("reset state done");
  endtask
  task automatic t_write();
    wr(1, 8'h00); cyc(1);
    `CHK({p1_pulldown, p1_weak_up}, 16'hff00)
    cyc(5); `CHK(p1_pins, 8'h00)
    wr(1, 8'hff); cyc(1);
    `CHK({p1_boost, p1_pulldown}, 16'hff00)
    cyc(2); `CHK({p1_boost, p1_weak_up}, 16'h00ff)
    $display("write zero then one done");
  endtask
  task automatic t_input();
    p1_en = 8'h80; cyc(6);
    `CHK({p1_pins[7], p1_pulldown}, 9'h000)
    p1_en = 8'h00; cyc(6); `CHK(p1_pins, 8'hff)
    $display("weak input done");
  endtask
  task automatic t_addr();
    ext_bus_active = 1; ext_addr_high = 8'h5a; cyc(5);
    `CHK({p2_pulldown, p2_latch, p2_pins}, 24'ha5ff5a)
    ext_bus_active = 0; cyc(1);
    `CHK({p2_pulldown, p2_boost, p2_weak_up}, 24'h00a5ff)
    $display("address byte done");
  endtask
  task automatic t_alt();
    {timer2_ext_out, serial1_tx, serial0_tx, ext_wr_strobe_n} = 4'h0; cyc(2);
    `CHK(p1_pulldown, 8'h09)
    `CHK(p3_pulldown, 8'h42)
    {timer2_ext_out, serial1_tx, serial0_tx, ext_wr_strobe_n} = 4'hf;
    ext_rd_strobe_n = 0; cyc(1);
    `CHK({p1_boost, p3_boost}, 16'h0942)
    wr(3, 8'hfd); cyc(1); `CHK(p3_pulldown, 8'h82)
    ext_rd_strobe_n = 1; wr(3, 8'hff); cyc(3);
    $display("alternate outputs done");
  endtask
  task automatic t_irq();
    drive_p1(8'h77); `CHK({r, fa, fb}, {32'd0, 32'd1, 32'd1})
    `CHK({timer2_ext_io, timer2_capture_trigger, serial1_rx}, 3'b000)
    drive_p1(8'h00); `CHK({r, fa, fb}, {32'd1, 32'd0, 32'd0})
    p3_en = 8'h3d; cyc(6);
    `CHK({serial0_rx, ext_irq_zero, ext_irq_one, timer0_input,
          timer1_input}, 5'b00000)
    `CHK(p3_pins, 8'hc2)
    p3_en = 8'h00; cyc(6);
    $display("interrupts and inputs done");
  endtask
  task automatic t_boot();
    external_program_select = 1;
    for (int i = 0; i < 10 && fetch_external !== 1'b0; i++) cyc(1);
    `CHK(fetch_external, 1'b0)
    external_program_select = 0;
    for (int i = 0; i < 10 && fetch_external !== 1'b1; i++) cyc(1);
    `CHK(fetch_external, 1'b1)
    rtc_load_select = 1; cyc(2); `CHK(rtc_load_high, 1'b1)
    rtc_load_select = 0; cyc(2); `CHK(rtc_load_high, 1'b0)
    $display("boot and load select done");
  endtask
  // ==========================================================
  // main sequence and hang guard
  initial begin
    cyc(20); reset_n = 1;
    t_reset(); t_write(); t_input(); t_addr(); t_alt(); t_irq(); t_boot();
    report_and_stop();
  end
  initial begin
    repeat (3000) @(posedge clock);
    errors++; $display("[ERR] %0t run timed out", $time);
    report_and_stop();
  end
endmodule // quasi_ports_test
`default_nettype wire
